// file: verilog/phy_aux_status_led_control.sv
// phy_aux_status_led_control: aux status, led mode and led behaviour regs
// assumes status and led events come from logic on clk_i, one cycle valid
// Overview of operation
// - bit 15: negotiation done, else link status
// - bit 14: inverse of negotiation enable
// - bit 13: crossover applied internally
// - bit 12: third and fourth pairs swapped
// - bits 11:8: polarity reversal pairs A-D
// - timeout code from bits 7 and 2
// - bits 4:3 report link speed
// - bits 1:0 report media selection
// - four-bit mode per led, defaults 5/4
// - bit 12 pulses active leds at 5 kHz
// - bits 11:10 pick blink and stretch rate
// - one rate shared by every led
// - rate writable only in port 0
// - bits 6/5 choose stretch or blink
// - bits 1/0 disable link/activity combining
`timescale 1ns/1ns
`default_nettype none
module phy_aux_status_led_control
    import pas_pkg::*;
#(
    parameter int unsigned TICK_CYC  = TICK_CYCLES,
    parameter int unsigned PORT_ID   = 0
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic [31:0]          wb_dat_o,
    output logic                 wb_ack_o,
    input  wire pas_phy_status_t status_i,
    input  wire pas_led_evt_t    led_evt_i,
    input  wire logic [1:0]      shared_rate_i,
    output logic [1:0]           blink_rate_o,
    output logic [1:0]           psave_timeout_o,
    output logic                 psave_enable_o,
    output logic                 first_indicator_output_o,
    output logic                 second_indicator_output_o
);
    // counters are sized for these ranges; refuse anything else
    if (TICK_CYC < 1) begin : g_tick_short
        $error("tick length must be at least one cycle");
    end
    if (TICK_CYC > 32'h0fff_ffff) begin : g_tick_long
        $error("tick length exceeds the tick counter");
    end
    if (PWM_STEP_CYC < 1 || PWM_STEP_CYC > 256) begin : g_pwm_step
        $error("pulse step length exceeds the step counter");
    end

    // sticky fields
    logic [1:0]  tmo_q;
    logic        ps_en_q;
    logic [3:0]  mode1_q;
    logic [3:0]  mode0_q;
    logic [1:0]  rate_q;
    logic        str1_q;
    logic        str0_q;
    logic        cmb1_q;
    logic        cmb0_q;
    // non-sticky fields
    logic        pulse_q;
    logic [7:0]  duty_q;
    // bus
    logic        req;
    logic        wr;
    logic        lo_wr;
    logic        hi_wr;
    logic [5:0]  idx;
    logic        srst;
    logic [15:0] rd_d;
    logic [15:0] aux_view;
    logic [1:0]  rate_eff;
    // timing
    logic [27:0] tick_cnt_q;
    logic        tick_en;
    logic [3:0]  half;
    logic [3:0]  half_cnt_q;
    logic        blink_q;
    logic [7:0]  pwm_div_q;
    logic [7:0]  pwm_ph_q;
    logic        pwm_on;

    // one wait state; ack falls the cycle after it rose
    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr    = req & wb_we_i;
    assign lo_wr = wr & wb_sel_i[0];
    assign hi_wr = wr & wb_sel_i[1];
    assign idx   = wb_adr_i[7:2];
    // soft reset restarts only non-sticky state
    assign srst  = hi_wr && idx == IDX_BLK_CTRL && wb_dat_i[CTL_SRST];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // auxiliary: timeout and power-save enable, sticky
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmo_q   <= RST_TMO;
            ps_en_q <= RST_PS_EN;
        end else if (lo_wr && idx == IDX_AUX) begin
            tmo_q   <= {wb_dat_i[AUX_TMO_MSB], wb_dat_i[AUX_TMO_LSB]};
            ps_en_q <= wb_dat_i[AUX_PS_EN];
        end
    end

    // led mode selectors, sticky
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode1_q <= RST_MODE1;
            mode0_q <= RST_MODE0;
        end else if (lo_wr && idx == IDX_LED_MODE) begin
            mode1_q <= wb_dat_i[7:4];
            mode0_q <= wb_dat_i[3:0];
        end
    end

    // led behaviour low byte, sticky
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            str1_q <= 1'b0;
            str0_q <= 1'b0;
            cmb1_q <= 1'b0;
            cmb0_q <= 1'b0;
        end else if (lo_wr && idx == IDX_LED_BEHAV) begin
            str1_q <= wb_dat_i[BEH_STR1];
            str0_q <= wb_dat_i[BEH_STR0];
            cmb1_q <= wb_dat_i[BEH_CMB1];
            cmb0_q <= wb_dat_i[BEH_CMB0];
        end
    end

    // rate field: only port 0 takes writes; other ports never store or act on it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_q <= RST_RATE;
        end else if (hi_wr && idx == IDX_LED_BEHAV && PORT_ID == 0) begin
            rate_q <= wb_dat_i[BEH_RATE_LSB +: 2];
        end
    end

    // pulse enable and duty follow the soft reset too
    always_ff @(posedge clk_i) begin
        if (rst_i || srst) begin
            pulse_q <= 1'b0;
            duty_q  <= RST_DUTY;
        end else begin
            if (hi_wr && idx == IDX_LED_BEHAV) begin
                pulse_q <= wb_dat_i[BEH_PULSE];
            end
            if (lo_wr && idx == IDX_BLK_CTRL) begin
                duty_q <= wb_dat_i[7:0];
            end
        end
    end

    // other ports follow port 0 so every led blinks alike
    assign rate_eff     = (PORT_ID == 0) ? rate_q : shared_rate_i;
    assign blink_rate_o = rate_eff;
    assign half         = pas_half_ticks(rate_eff);

    always_comb begin
        aux_view = 16'h0;
        aux_view[AUX_AN_DONE] = status_i.an_enable ? status_i.an_complete
                                                   : status_i.link_up;
        aux_view[AUX_AN_OFF]  = ~status_i.an_enable;
        aux_view[AUX_XOVER]   = status_i.crossover;
        aux_view[AUX_PAIR_X]  = status_i.third_fourth_pair_exchanged;
        aux_view[AUX_POL_LSB +: 4] = {status_i.polarity[0],
                                      status_i.polarity[1],
                                      status_i.polarity[2],
                                      status_i.polarity[3]};
        aux_view[AUX_TMO_MSB] = tmo_q[1];
        aux_view[AUX_PS_EN]   = ps_en_q;
        aux_view[AUX_DUPLEX]  = status_i.duplex_status;
        aux_view[AUX_SPD_LSB +: 2]   = status_i.speed;
        aux_view[AUX_TMO_LSB] = tmo_q[0];
        aux_view[AUX_MEDIA_LSB +: 2] = status_i.media;
    end

    // unmapped and reserved positions read zero
    always_comb begin
        rd_d = 16'h0;
        unique case (idx)
            IDX_AUX:       rd_d = aux_view;
            IDX_LED_MODE:  rd_d = {8'h0, mode1_q, mode0_q};
            IDX_LED_BEHAV: begin
                rd_d[BEH_PULSE]         = pulse_q;
                rd_d[BEH_RATE_LSB +: 2] = rate_eff;
                rd_d[BEH_STR1]          = str1_q;
                rd_d[BEH_STR0]          = str0_q;
                rd_d[BEH_CMB1]          = cmb1_q;
                rd_d[BEH_CMB0]          = cmb0_q;
            end
            IDX_BLK_CTRL:  rd_d = {8'h0, duty_q};
            default:       rd_d = 16'h0;
        endcase
    end

    // read data holds until the next read is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= {16'h0, rd_d};
        end
    end

    // only the code leaves here; the timeout itself is timed elsewhere
    assign psave_timeout_o = tmo_q;
    assign psave_enable_o  = ps_en_q;

    // 25 ms tick, the unit of every blink and stretch time
    always_ff @(posedge clk_i) begin
        if (rst_i || tick_en) begin
            tick_cnt_q <= 28'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 28'h1;
        end
    end
    // a new rate is picked up at the next tick, not mid count
    assign tick_en = tick_cnt_q == 28'(TICK_CYC - 1);

    // one blink phase for all leds keeps them in step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_cnt_q <= 4'h0;
            blink_q    <= 1'b0;
        end else if (tick_en) begin
            if (half_cnt_q + 4'h1 >= half) begin
                half_cnt_q <= 4'h0;
                blink_q    <= ~blink_q;
            end else begin
                half_cnt_q <= half_cnt_q + 4'h1;
            end
        end
    end

    // pulsing: 256 phase steps per 5 kHz period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_div_q <= 8'h0;
            pwm_ph_q  <= 8'h0;
        end else if (pwm_div_q == 8'(PWM_STEP_CYC - 1)) begin
            pwm_div_q <= 8'h0;
            pwm_ph_q  <= pwm_ph_q + 8'h1;
        end else begin
            pwm_div_q <= pwm_div_q + 8'h1;
        end
    end
    // duty 0 keeps pulsed leds dark
    assign pwm_on = pwm_ph_q < duty_q;

    // both drivers share tick, blink phase and pulse phase
    pas_led_drv u_first_indicator_output (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .tick_en_i     (tick_en),
        .half_ticks_i  (half),
        .blink_phase_i (blink_q),
        .pwm_on_i      (pwm_on),
        .pulse_en_i    (pulse_q),
        .mode_i        (mode0_q),
        .stretch_sel_i (str0_q),
        .combine_off_i (cmb0_q),
        .evt_i         (led_evt_i),
        .led_o         (first_indicator_output_o)
    );

    pas_led_drv u_second_indicator_output (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .tick_en_i     (tick_en),
        .half_ticks_i  (half),
        .blink_phase_i (blink_q),
        .pwm_on_i      (pwm_on),
        .pulse_en_i    (pulse_q),
        .mode_i        (mode1_q),
        .stretch_sel_i (str1_q),
        .combine_off_i (cmb1_q),
        .evt_i         (led_evt_i),
        .led_o         (second_indicator_output_o)
    );
endmodule : phy_aux_status_led_control
`default_nettype wire

// file: verilog/pas_pkg.sv
// pas_pkg: constants and carrier types for the aux status / led block
// assumes a single 100 MHz clock shared by all users of the package
package pas_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_AUX        = 6'h1c;
    localparam logic [5:0] IDX_LED_MODE   = 6'h1d;
    localparam logic [5:0] IDX_LED_BEHAV  = 6'h1e;
    localparam logic [5:0] IDX_BLK_CTRL   = 6'h20;
    // auxiliary register field positions
    localparam int AUX_AN_DONE   = 15;
    localparam int AUX_AN_OFF    = 14;
    localparam int AUX_XOVER     = 13;
    localparam int AUX_PAIR_X    = 12;
    localparam int AUX_POL_LSB   = 8;
    localparam int AUX_TMO_MSB   = 7;
    localparam int AUX_PS_EN     = 6;
    localparam int AUX_DUPLEX    = 5;
    localparam int AUX_SPD_LSB   = 3;
    localparam int AUX_TMO_LSB   = 2;
    localparam int AUX_MEDIA_LSB = 0;
    // led behaviour field positions
    localparam int BEH_PULSE     = 12;
    localparam int BEH_RATE_LSB  = 10;
    localparam int BEH_STR1      = 6;
    localparam int BEH_STR0      = 5;
    localparam int BEH_CMB1      = 1;
    localparam int BEH_CMB0      = 0;
    // block control field positions
    localparam int CTL_SRST      = 15;
    // values after reset
    localparam logic [1:0] RST_TMO       = 2'h1;
    localparam logic       RST_PS_EN     = 1'b0;
    localparam logic [3:0] RST_MODE1     = 4'h5;
    localparam logic [3:0] RST_MODE0     = 4'h4;
    localparam logic [1:0] RST_RATE      = 2'h1;
    localparam logic [7:0] RST_DUTY      = 8'h80;
    // timing: blink half periods are multiples of a 25 ms tick
    localparam int unsigned TICK_MS      = 25;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned PWM_HZ       = 5000;
    localparam int unsigned PWM_STEPS    = 256;
    localparam int unsigned PWM_STEP_CYC = CLK_HZ / PWM_HZ / PWM_STEPS;

    typedef struct packed {
        logic       an_enable;
        logic       an_complete;
        logic       link_up;
        logic       crossover;
        logic       third_fourth_pair_exchanged;
        logic [3:0] polarity;
        logic       duplex_status;
        logic [1:0] speed;
        logic [1:0] media;
    } pas_phy_status_t;

    typedef struct packed {
        logic [15:0] sources;
        logic        activity;
    } pas_led_evt_t;

    // blink half period in 25 ms ticks: 200, 100, 50, 25 ms
    function automatic logic [3:0] pas_half_ticks(input logic [1:0] rate);
        unique case (rate)
            2'h0: pas_half_ticks = 4'h8;
            2'h1: pas_half_ticks = 4'h4;
            2'h2: pas_half_ticks = 4'h2;
            2'h3: pas_half_ticks = 4'h1;
        endcase
    endfunction : pas_half_ticks
endpackage : pas_pkg

// file: verilog/pas_led_drv.sv
// pas_led_drv: one indicator output, mode select, stretch/blink, pulsing
// assumes tick_en and blink_phase_i are shared by all indicators
`timescale 1ns/1ns
`default_nettype none
module pas_led_drv
    import pas_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_en_i,
    input  wire logic [3:0]   half_ticks_i,
    input  wire logic         blink_phase_i,
    input  wire logic         pwm_on_i,
    input  wire logic         pulse_en_i,
    input  wire logic [3:0]   mode_i,
    input  wire logic         stretch_sel_i,
    input  wire logic         combine_off_i,
    input  wire pas_led_evt_t evt_i,
    output logic              led_o
);
    logic [4:0] stretch_q;
    logic       level;
    logic       act;
    logic       shown;

    // stretch lasts two half periods: 400, 200, 100 or 50 ms
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stretch_q <= 5'h0;
        end else if (evt_i.activity) begin
            stretch_q <= {half_ticks_i, 1'b0};
        end else if (tick_en_i && stretch_q != 5'h0) begin
            stretch_q <= stretch_q - 5'h1;
        end
    end

    always_comb begin
        level = evt_i.sources[mode_i];
        act   = stretch_q != 5'h0;
        if (combine_off_i) begin
            shown = level;
        end else if (stretch_sel_i) begin
            shown = level & ~act;
        end else begin
            shown = level & ~(act & blink_phase_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_o <= 1'b0;
        end else begin
            led_o <= shown & (~pulse_en_i | pwm_on_i);
        end
    end
endmodule : pas_led_drv
`default_nettype wire

// file: tb/pas_chk.sv
// pas_chk: port-level checks of the aux status / led block
// assumes binding to the top module, one clock, PORT_ID 0 rate path
`timescale 1ns/1ns
`default_nettype none
module pas_chk
    import pas_pkg::*;
#(
    parameter int unsigned TICK_CYC = 4,
    parameter int unsigned PORT_ID  = 0
) (
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire pas_phy_status_t status_i,
    input wire logic [1:0]      blink_rate_o,
    input wire logic [1:0]      psave_timeout_o,
    input wire logic            psave_enable_o
);
    logic            take;
    logic            rd_aux;
    logic            wr_aux;
    logic            wr_beh;
    logic [31:0]     dat_q;
    pas_phy_status_t st_q;
    assign take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_aux = take & ~wb_we_i & (wb_adr_i[7:2] == IDX_AUX);
    assign wr_aux = take & wb_we_i & wb_sel_i[0] & (wb_adr_i[7:2] == IDX_AUX);
    assign wr_beh = take & wb_we_i & wb_sel_i[1]
                    & (wb_adr_i[7:2] == IDX_LED_BEHAV);
    // status is live at the take edge, so keep a copy of it
    always_ff @(posedge clk_i) begin
        st_q  <= status_i;
        dat_q <= wb_dat_i;
    end
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_an_done;
        rd_aux |=> wb_dat_o[15] == (st_q.an_enable ? st_q.an_complete
                                                   : st_q.link_up);
    endproperty
    a_an_done: assert property (p_an_done)
        else $error("negotiation done bit wrong");
    property p_an_off;
        rd_aux |=> wb_dat_o[14] == !st_q.an_enable;
    endproperty
    a_an_off: assert property (p_an_off)
        else $error("negotiation off bit wrong");
    property p_pairs;
        rd_aux |=> wb_dat_o[13:12] ==
            {st_q.crossover, st_q.third_fourth_pair_exchanged};
    endproperty
    a_pairs: assert property (p_pairs)
        else $error("crossover or swap bit wrong");
    property p_pol;
        rd_aux |=> wb_dat_o[11:8] == {st_q.polarity[0], st_q.polarity[1],
                                      st_q.polarity[2], st_q.polarity[3]};
    endproperty
    a_pol: assert property (p_pol)
        else $error("polarity bits wrong");
    property p_spd;
        rd_aux |=> {wb_dat_o[5:3], wb_dat_o[1:0]} ==
            {st_q.duplex_status, st_q.speed, st_q.media};
    endproperty
    a_spd: assert property (p_spd)
        else $error("speed, duplex or media wrong");
    property p_tmo;
        wr_aux |=> psave_timeout_o == {dat_q[7], dat_q[2]}
                   && psave_enable_o == dat_q[6] ##1 wb_ack_o == 1'b0;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout field not taken from bits 7 and 2");
    property p_rate;
        wr_beh && PORT_ID == 0 |=> blink_rate_o == dat_q[11:10];
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate field not applied");
    property p_dflt;
        $fell(rst_i) |-> blink_rate_o == RST_RATE
                         && psave_timeout_o == RST_TMO && !psave_enable_o;
    endproperty
    a_dflt: assert property (p_dflt)
        else $error("field default wrong");
    property p_hi_zero;
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0 ##1 !wb_ack_o;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read bits not zero");
endmodule : pas_chk

bind phy_aux_status_led_control pas_chk #(
    .TICK_CYC(TICK_CYC),
    .PORT_ID (PORT_ID)
) u_chk (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .status_i       (status_i),
    .blink_rate_o   (blink_rate_o),
    .psave_timeout_o(psave_timeout_o),
    .psave_enable_o (psave_enable_o)
);
`default_nettype wire

// file: tb/tb.sv
// tb: self-checking bench for the aux status / led block
// assumes the checker file is compiled first; short tick for speed
`timescale 1ns/1ns
`default_nettype none
module tb
    import pas_pkg::*;
;
    localparam logic [7:0] A_AUX = {IDX_AUX, 2'h0};
    localparam logic [7:0] A_MOD = {IDX_LED_MODE, 2'h0};
    localparam logic [7:0] A_BEH = {IDX_LED_BEHAV, 2'h0};
    localparam logic [7:0] A_CTL = {IDX_BLK_CTRL, 2'h0};
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            cyc   = 1'b0;
    logic            stb   = 1'b0;
    logic            we    = 1'b0;
    logic [7:0]      adr   = 8'h0;
    logic [3:0]      sel   = 4'h0;
    logic [31:0]     wdat  = 32'h0;
    logic [31:0]     rdat;
    logic            ack;
    pas_phy_status_t st    = '0;
    pas_led_evt_t    evt   = '0;
    logic [1:0]      rate;
    logic [1:0]      tmo;
    logic            pse;
    logic            first_indicator_output;
    logic            second_indicator_output;
    int              failures = 0;
    int              checked  = 0;

    always #5 clk_i = ~clk_i;

    phy_aux_status_led_control #(.TICK_CYC(4), .PORT_ID(0)) DUT (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .wb_cyc_i                 (cyc),
        .wb_stb_i                 (stb),
        .wb_we_i                  (we),
        .wb_adr_i                 (adr),
        .wb_sel_i                 (sel),
        .wb_dat_i                 (wdat),
        .wb_dat_o                 (rdat),
        .wb_ack_o                 (ack),
        .status_i                 (st),
        .led_evt_i                (evt),
        .shared_rate_i            (2'h0),
        .blink_rate_o             (rate),
        .psave_timeout_o          (tmo),
        .psave_enable_o           (pse),
        .first_indicator_output_o (first_indicator_output),
        .second_indicator_output_o(second_indicator_output)
    );

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    // bus cycle; waits on ack with a bound, never a fixed count
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [15:0] d, input logic [3:0] s,
                        output logic [15:0] r);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cmp({15'h0, ack}, 16'h1);
        r = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] r;
        xfer(1'b1, a, d, 4'h3, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] r;
        xfer(1'b0, a, 16'h0, 4'h3, r);
        cmp(r, e);
    endtask : rd

    function automatic logic [15:0] exp_aux(input pas_phy_status_t s,
                                            input logic [1:0] t,
                                            input logic e);
        return {s.an_enable ? s.an_complete : s.link_up, ~s.an_enable,
                s.crossover, s.third_fourth_pair_exchanged,
                s.polarity[0], s.polarity[1], s.polarity[2],
                s.polarity[3], t[1], e, s.duplex_status, s.speed, t[0],
                s.media};
    endfunction : exp_aux

    task automatic t_aux;
        pas_phy_status_t p [3];
        p[0] = 14'h3fff;
        p[1] = 14'h2a29;
        p[2] = 14'h1514;
        rd(A_AUX, 16'h4004);
        wr(A_AUX, 16'hffff);
        cmp({13'h0, tmo, pse}, 16'h7);
        for (int i = 0; i < 3; i++) begin
            st <= p[i];
            rd(A_AUX, exp_aux(p[i], 2'h3, 1'b1));
        end
        wr(A_AUX, 16'h0080);
        cmp({13'h0, tmo, pse}, 16'h4);
        $display("test aux done");
    endtask : t_aux

    task automatic t_regs;
        logic [15:0] r;
        rd(A_MOD, 16'h0054);
        rd(A_BEH, 16'h0400);
        for (int k = 0; k < 4; k++) begin
            wr(A_BEH, {4'h0, k[1:0], 10'h0});
            cmp({14'h0, rate}, {14'h0, k[1:0]});
        end
        wr(A_MOD, 16'hffff);
        rd(A_MOD, 16'h00ff);
        xfer(1'b1, A_MOD, 16'h0000, 4'h2, r);
        rd(A_MOD, 16'h00ff);
        wr(A_BEH, 16'hffff);
        rd(A_BEH, 16'h1c63);
        wr(8'h40, 16'hffff);
        rd(8'h40, 16'h0000);
        wr(A_CTL, 16'h8000);
        rd(A_CTL, 16'h0080);
        rd(A_BEH, 16'h0c63);
        rd(A_MOD, 16'h00ff);
        $display("test registers done");
    endtask : t_regs

    // combine off so each output is a plain view of its source
    task automatic t_led;
        wr(A_MOD, 16'h0054);
        wr(A_BEH, 16'h0003);
        evt.sources <= 16'h0010;
        repeat (4) @(posedge clk_i);
        cmp({14'h0, second_indicator_output, first_indicator_output}, 16'h1);
        evt.sources <= 16'h0020;
        repeat (4) @(posedge clk_i);
        cmp({14'h0, second_indicator_output, first_indicator_output}, 16'h2);
        wr(A_MOD, 16'h0045);
        repeat (4) @(posedge clk_i);
        cmp({14'h0, second_indicator_output, first_indicator_output}, 16'h1);
        $display("test leds done");
    endtask : t_led

    // one activity pulse blanks a stretched led, then pulsing at duty 0
    task automatic t_act;
        wr(A_BEH, 16'h0c20);
        evt.activity <= 1'b1;
        @(posedge clk_i);
        evt.activity <= 1'b0;
        repeat (2) @(posedge clk_i);
        cmp({15'h0, first_indicator_output}, 16'h0);
        repeat (12) @(posedge clk_i);
        cmp({15'h0, first_indicator_output}, 16'h1);
        wr(A_CTL, 16'h0000);
        rd(A_CTL, 16'h0000);
        wr(A_BEH, 16'h1003);
        repeat (4) @(posedge clk_i);
        cmp({15'h0, first_indicator_output}, 16'h0);
        wr(A_BEH, 16'h0003);
        repeat (4) @(posedge clk_i);
        cmp({15'h0, first_indicator_output}, 16'h1);
        $display("test activity and pulsing done");
    endtask : t_act

    task automatic t_hard;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_MOD, 16'h0054);
        rd(A_BEH, 16'h0400);
        $display("test hard reset done");
    endtask : t_hard

    task automatic print_verdict;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        failures++;
        $display("watchdog expired at t=%0t", $time);
        print_verdict;
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_aux;
        t_regs;
        t_led;
        t_act;
        t_hard;
        print_verdict;
    end
endmodule : tb
`default_nettype wire
